// ---- core/ira_bank.sv ----
// eight-bit internal control register bank behind the access port
`timescale 1ns/100ps
`default_nettype none
`include "ira_cfg.svh"
module ira_bank (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] fault_status,
    ira_bank_if.bank bus,
    output logic [7:0] port_ctrl_a,
    output logic [7:0] port_ctrl_b,
    output logic soft_reset_pulse
);
    // ****************************************
    // decode
    // ****************************************
    function automatic logic mapped(input logic [3:0] t, input logic [2:0] i);
        case (t)
            `IRA_T_RING_READY: mapped = (i <= 3'h5);
            `IRA_T_MEDIUM_RX: mapped = (i <= 3'h1)
                || (i == 3'h4) || (i == 3'h5);
            `IRA_T_HEADER: mapped = (i == 3'h4);
            `IRA_T_RX_BUF: mapped = (i == 3'h4) || (i == 3'h5);
            `IRA_T_WATERMARK: mapped = 1'b1;
            `IRA_T_LIMIT: mapped = (i <= 3'h5);
            `IRA_T_RING_PARAM: mapped = 1'b1;
            `IRA_T_PARAM_EXT: mapped = 1'b1;
            `IRA_T_PAGE: mapped = (i >= 3'h6);
            `IRA_T_DEST_READY: mapped = (i <= 3'h3) || (i >= 3'h6);
            `IRA_T_PORT_CTRL: mapped = (i >= 3'h6);
            `IRA_T_RX_SPACE: mapped = (i == 3'h4) || (i == 3'h5);
            `IRA_T_SIGNAL: mapped = 1'b1;
            `IRA_T_RING_STATE: mapped = 1'b1;
            `IRA_T_MISC: mapped = (i == `IRA_I_FAULT) || (i == `IRA_I_VERSION)
                || (i == 3'h4) || (i == 3'h5) || (i == `IRA_I_SOFT_RESET);
            default: mapped = 1'b0;
        endcase
    endfunction

    logic [7:0] mem_reg [0:127];
    logic done_reg;
    logic done_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic soft_reg;
    logic soft_next;
    logic wr_en;
    logic [6:0] addr;
    logic hit;
    logic is_misc;

    // ****************************************
    // access
    // ****************************************
    always_comb begin
        addr = {bus.rtype, bus.rindex};
        hit = mapped(bus.rtype, bus.rindex);
        is_misc = (bus.rtype == `IRA_T_MISC);
        wr_en = bus.req && bus.write && hit
            && !(is_misc && (bus.rindex == `IRA_I_FAULT
            || bus.rindex == `IRA_I_VERSION));
        done_next = bus.req;
        soft_next = bus.req && bus.write && is_misc
            && (bus.rindex == `IRA_I_SOFT_RESET);
        rdata_next = rdata_reg;
        if (bus.req && !bus.write) begin
            if (!hit) begin
                rdata_next = 8'h00;
            end else if (is_misc && bus.rindex == `IRA_I_FAULT) begin
                rdata_next = fault_status;
            end else if (is_misc && bus.rindex == `IRA_I_VERSION) begin
                rdata_next = `IRA_VERSION_VALUE;
            end else begin
                rdata_next = mem_reg[addr];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int k = 0; k < 128; k++) begin
                mem_reg[k] <= `IRA_REG_RESET;
            end
            done_reg <= 1'b0;
            rdata_reg <= 8'h00;
            soft_reg <= 1'b0;
        end else begin
            if (wr_en) begin
                mem_reg[addr] <= bus.wdata;
            end
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            soft_reg <= soft_next;
        end
    end

    assign bus.done = done_reg;
    assign bus.rdata = rdata_reg;
    assign port_ctrl_a = mem_reg[{`IRA_T_PORT_CTRL, 3'h6}];
    assign port_ctrl_b = mem_reg[{`IRA_T_PORT_CTRL, 3'h7}];
    assign soft_reset_pulse = soft_reg;
endmodule
`default_nettype wire

// ---- core/ira_bank_if.sv ----
// request and answer carrier between access port and register bank
`timescale 1ns/100ps
`default_nettype none
interface ira_bank_if;
    logic req;
    logic write;
    ira_pkg::ira_type_t rtype;
    ira_pkg::ira_index_t rindex;
    ira_pkg::ira_byte_t wdata;
    logic done;
    ira_pkg::ira_byte_t rdata;
    modport port (output req, output write, output rtype, output rindex,
        output wdata, input done, input rdata);
    modport bank (input req, input write, input rtype, input rindex,
        input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ---- core/ira_cfg.svh ----
// offsets, field positions, codes and reset values of the access port
`ifndef IRA_CFG_SVH
`define IRA_CFG_SVH
`define IRA_SEL_CMD_EXT 4'hb
`define IRA_SEL_ACCESS 4'hf
`define IRA_BIT_READ 31
`define IRA_TYPE_HI 30
`define IRA_TYPE_LO 27
`define IRA_INDEX_HI 26
`define IRA_INDEX_LO 24
`define IRA_DATA_HI 23
`define IRA_DATA_LO 16
`define IRA_T_RING_READY 4'h0
`define IRA_T_MEDIUM_RX 4'h1
`define IRA_T_HEADER 4'h2
`define IRA_T_RX_BUF 4'h3
`define IRA_T_WATERMARK 4'h4
`define IRA_T_LIMIT 4'h5
`define IRA_T_RING_PARAM 4'h6
`define IRA_T_PARAM_EXT 4'h7
`define IRA_T_PAGE 4'h8
`define IRA_T_DEST_READY 4'h9
`define IRA_T_PORT_CTRL 4'hb
`define IRA_T_RX_SPACE 4'hc
`define IRA_T_SIGNAL 4'hd
`define IRA_T_RING_STATE 4'he
`define IRA_T_MISC 4'hf
`define IRA_I_FAULT 3'h0
`define IRA_I_VERSION 3'h2
`define IRA_I_SOFT_RESET 3'h7
`define IRA_VERSION_VALUE 8'h5a
`define IRA_CMD_EXT_RESET 32'h0000_0000
`define IRA_REG_RESET 8'h00
`endif

// ---- core/ira_pkg.sv ----
// types shared by the access port modules
package ira_pkg;
    typedef logic [3:0] ira_type_t;
    typedef logic [2:0] ira_index_t;
    typedef logic [7:0] ira_byte_t;
    typedef enum logic [1:0] {
        IRA_IDLE = 2'b00,
        IRA_ISSUE = 2'b01,
        IRA_WAIT = 2'b10
    } ira_state_t;
endpackage

// ---- core/ira_top.sv ----
// two-port host access: command extension and indirect access registers
`timescale 1ns/100ps
`default_nettype none
`include "ira_cfg.svh"
module ira_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] host_write,
    input wire logic [1:0] host_read,
    input wire logic [1:0][3:0] direct_register_select,
    input wire logic [1:0][31:0] host_wdata,
    output logic [1:0][31:0] host_rdata,
    output logic [1:0] access_port_free_flag,
    input wire logic [7:0] fault_status,
    output logic [7:0] port_ctrl_a,
    output logic [7:0] port_ctrl_b,
    output logic soft_reset_pulse
);
    ira_bank_if bus ();

    logic [1:0][31:0] cmd_ext_reg;
    logic [1:0][31:0] cmd_ext_next;
    logic [1:0][31:0] access_reg;
    logic [1:0][31:0] access_next;
    logic [1:0] free_reg;
    logic [1:0] free_next;
    logic [1:0] pend_reg;
    logic [1:0] pend_next;
    logic [1:0][31:0] rdata_reg;
    logic [1:0][31:0] rdata_next;
    ira_pkg::ira_state_t state_reg;
    ira_pkg::ira_state_t state_next;
    logic owner_reg;
    logic owner_next;
    logic [7:0] pc_a_reg;
    logic [7:0] pc_b_reg;
    logic soft_reg;
    logic [7:0] pc_a_w;
    logic [7:0] pc_b_w;
    logic soft_w;

    // ****************************************
    // host registers and arbitration
    // ****************************************
    always_comb begin
        cmd_ext_next = cmd_ext_reg;
        access_next = access_reg;
        free_next = free_reg;
        pend_next = pend_reg;
        rdata_next = rdata_reg;
        state_next = state_reg;
        owner_next = owner_reg;
        for (int p = 0; p < 2; p++) begin
            if (host_write[p]
                && direct_register_select[p] == `IRA_SEL_CMD_EXT) begin
                cmd_ext_next[p] = host_wdata[p];
            end
            if (host_write[p] && direct_register_select[p] == `IRA_SEL_ACCESS
                && free_reg[p]) begin
                access_next[p] = {host_wdata[p][31:16], 16'h0000};
                free_next[p] = 1'b0;
                pend_next[p] = 1'b1;
            end
            if (host_read[p]) begin
                case (direct_register_select[p])
                    `IRA_SEL_CMD_EXT: rdata_next[p] = cmd_ext_reg[p];
                    `IRA_SEL_ACCESS: rdata_next[p] = access_reg[p];
                    default: rdata_next[p] = 32'h0000_0000;
                endcase
            end
        end
        case (state_reg)
            ira_pkg::IRA_IDLE: begin
                if (pend_reg != 2'b00) begin
                    owner_next = !pend_reg[0];
                    state_next = ira_pkg::IRA_ISSUE;
                end
            end
            ira_pkg::IRA_ISSUE: begin
                state_next = ira_pkg::IRA_WAIT;
            end
            ira_pkg::IRA_WAIT: begin
                if (bus.done) begin
                    if (access_reg[owner_reg][`IRA_BIT_READ]) begin
                        access_next[owner_reg][`IRA_DATA_HI:`IRA_DATA_LO] =
                            bus.rdata;
                    end
                    free_next[owner_reg] = 1'b1;
                    pend_next[owner_reg] = 1'b0;
                    state_next = ira_pkg::IRA_IDLE;
                end
            end
            default: state_next = ira_pkg::IRA_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmd_ext_reg <= {2{`IRA_CMD_EXT_RESET}};
            access_reg <= '0;
            free_reg <= 2'b11;
            pend_reg <= 2'b00;
            rdata_reg <= '0;
            state_reg <= ira_pkg::IRA_IDLE;
            owner_reg <= 1'b0;
            pc_a_reg <= 8'h00;
            pc_b_reg <= 8'h00;
            soft_reg <= 1'b0;
        end else begin
            cmd_ext_reg <= cmd_ext_next;
            access_reg <= access_next;
            free_reg <= free_next;
            pend_reg <= pend_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            owner_reg <= owner_next;
            pc_a_reg <= pc_a_w;
            pc_b_reg <= pc_b_w;
            soft_reg <= soft_w;
        end
    end

    // ****************************************
    // bank request
    // ****************************************
    assign bus.req = (state_reg == ira_pkg::IRA_ISSUE);
    assign bus.write = !access_reg[owner_reg][`IRA_BIT_READ];
    assign bus.rtype = access_reg[owner_reg][`IRA_TYPE_HI:`IRA_TYPE_LO];
    assign bus.rindex = access_reg[owner_reg][`IRA_INDEX_HI:`IRA_INDEX_LO];
    assign bus.wdata = access_reg[owner_reg][`IRA_DATA_HI:`IRA_DATA_LO];

    ira_bank u_bank (
        .clock(clock),
        .reset_n(reset_n),
        .fault_status(fault_status),
        .bus(bus),
        .port_ctrl_a(pc_a_w),
        .port_ctrl_b(pc_b_w),
        .soft_reset_pulse(soft_w)
    );

    assign host_rdata = rdata_reg;
    assign access_port_free_flag = free_reg;
    assign port_ctrl_a = pc_a_reg;
    assign port_ctrl_b = pc_b_reg;
    assign soft_reset_pulse = soft_reg;
endmodule
`default_nettype wire

// ---- dv/indirect_register_access_tb_top.sv ----
// self-checking bench of the two-port access block
`timescale 1ns/100ps
`default_nettype none
`include "ira_cfg.svh"
module indirect_register_access_tb_top;
    // ********
    // bench
    // ********
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] fault_status = 8'h3c;
    logic [1:0] host_write;
    logic [1:0] host_read;
    logic [1:0][3:0] direct_register_select;
    logic [1:0][31:0] host_wdata;
    logic [1:0][31:0] host_rdata;
    logic [1:0] access_port_free_flag;
    logic [7:0] port_ctrl_a;
    logic [7:0] port_ctrl_b;
    logic soft_reset_pulse;
    int num_errors = 0;
    int check_count = 0;
    int pulses = 0;
    logic [7:0] q;
    logic [7:0] qb;
    logic [31:0] w;
    always #10 clock = ~clock;
    always @(posedge clock) if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
    ira_top ira_top_i (.clock, .reset_n, .host_write, .host_read,
        .direct_register_select, .host_wdata, .host_rdata,
        .access_port_free_flag, .fault_status, .port_ctrl_a,
        .port_ctrl_b, .soft_reset_pulse);
    ira_host ira_host_i (.clock, .host_write, .host_read,
        .direct_register_select, .host_wdata, .host_rdata,
        .access_port_free_flag);
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic mapped(logic [3:0] t, logic [2:0] i);
        case (t)
            4'h0, 4'h5: return i <= 3'h5;
            4'h1: return i <= 3'h1 || i[2:1] == 2'b10;
            4'h2: return i == 3'h4;
            4'h3, 4'hc, 4'hf: return i[2:1] == 2'b10;
            4'h8, 4'hb: return i[2:1] == 2'b11;
            4'h9: return i != 3'h4 && i != 3'h5;
            4'ha: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction
    function automatic logic [7:0] expv(logic [3:0] t, logic [2:0] i);
        if (t == 4'hf && i == 3'h0) return fault_status;
        if (t == 4'hf && i == 3'h2) return `IRA_VERSION_VALUE;
        return mapped(t, i) ? {t, 1'b1, i} : 8'h00;
    endfunction
    task end_of_test;
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        #1 reset_n = 1'b1;
        chk("free", 32'h3, {30'h0, access_port_free_flag});
        ira_host_i.wr(0, 4'hb, 32'ha5a5_0f0f);
        ira_host_i.wr(1, 4'hb, 32'h1234_5678);
        ira_host_i.rd(0, 4'hb, w);
        chk("ext a", 32'ha5a5_0f0f, w);
        ira_host_i.rd(1, 4'hb, w);
        chk("ext b", 32'h1234_5678, w);
        ira_host_i.rd(0, 4'h3, w);
        chk("unsel", 32'h0, w);
        for (int k = 0; k < 127; k++) begin
            ira_host_i.acc(k % 2, 1'b0, k[6:3], k[2:0],
                {k[6:3], 1'b1, k[2:0]}, q);
        end
        chk("ctrl a", 32'hbe, {24'h0, port_ctrl_a});
        chk("ctrl b", 32'hbf, {24'h0, port_ctrl_b});
        for (int k = 0; k < 127; k++) begin
            ira_host_i.acc((k + 1) % 2, 1'b1, k[6:3], k[2:0], 8'h00, q);
            chk("reg", {24'h0, expv(k[6:3], k[2:0])}, {24'h0, q});
        end
        ira_host_i.acc(0, 1'b0, 4'hf, 3'h7, 8'h01, q);
        chk("pulses", 32'h1, pulses);
        fork
            ira_host_i.acc(0, 1'b0, 4'h4, 3'h1, 8'h11, q);
            ira_host_i.acc(1, 1'b0, 4'h4, 3'h2, 8'h22, qb);
        join
        fork
            ira_host_i.acc(0, 1'b1, 4'h4, 3'h2, 8'h00, q);
            ira_host_i.acc(1, 1'b1, 4'h4, 3'h1, 8'h00, qb);
        join
        chk("cross a", 32'h22, {24'h0, q});
        chk("cross b", 32'h11, {24'h0, qb});
        ira_host_i.wr(0, 4'hf, {1'b0, 4'h4, 3'h3, 8'h33, 16'h0000});
        ira_host_i.wr(0, 4'hf, {1'b0, 4'h4, 3'h3, 8'h44, 16'h0000});
        ira_host_i.acc(0, 1'b1, 4'h4, 3'h3, 8'h00, q);
        chk("busy write", 32'h33, {24'h0, q});
        chk("timeouts", 32'h0, ira_host_i.timeouts);
        end_of_test;
    end
endmodule
`default_nettype wire

// ---- dv/ira_assertions.sv ----
// timing checker of the access port, seen at the top ports
`timescale 1ns/100ps
`default_nettype none
module ira_assertions (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] host_write,
    input wire logic [1:0] host_read,
    input wire logic [1:0][3:0] direct_register_select,
    input wire logic [1:0][31:0] host_rdata,
    input wire logic [1:0] access_port_free_flag,
    input wire logic [7:0] port_ctrl_a,
    input wire logic soft_reset_pulse
);
    // ********
    // properties
    // ********
    logic acc_a;
    logic ext_a;
    logic [1:0] ff;
    assign acc_a = host_write[0] && direct_register_select[0] == 4'hf;
    assign ext_a = host_write[0] && direct_register_select[0] == 4'hb;
    assign ff = access_port_free_flag;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_take_a; acc_a && ff[0] |=> !ff[0]; endproperty
    a_take_a: assert property (p_take_a) else $error("free a kept");
    property p_busy_a; $fell(ff[0]) |-> !ff[0] [*3]; endproperty
    a_busy_a: assert property (p_busy_a) else $error("free a early");
    property p_done_a; $fell(ff[0]) |-> ##[1:24] ff[0]; endproperty
    a_done_a: assert property (p_done_a) else $error("free a stuck");
    property p_done_b; $fell(ff[1]) |-> ##[1:24] ff[1]; endproperty
    a_done_b: assert property (p_done_b) else $error("free b stuck");
    property p_ext_a; ext_a && ff[0] |=> ff[0]; endproperty
    a_ext_a: assert property (p_ext_a) else $error("ext write busy");
    property p_low_zero;
        host_read[0] && direct_register_select[0] == 4'hf
            |=> host_rdata[0][15:0] == 16'h0000;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low half");
    property p_unsel;
        host_read[0] && direct_register_select[0] == 4'h3
            |=> host_rdata[0] == 32'h0000_0000;
    endproperty
    a_unsel: assert property (p_unsel) else $error("unsel read");
    property p_pulse; soft_reset_pulse |=> !soft_reset_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse long");
    property p_pulse_why; soft_reset_pulse |-> $past(ff, 2) != 2'b11; endproperty
    a_pulse_why: assert property (p_pulse_why) else $error("pulse idle");
    property p_ctrl; $changed(port_ctrl_a) |-> $past(ff, 2) != 2'b11; endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl idle");
    c_take: cover property (acc_a && ff[0]);
    c_b: cover property ($fell(ff[1]));
    c_pulse: cover property (soft_reset_pulse);
endmodule
bind ira_top ira_assertions ira_assertions_i (.clock, .reset_n, .host_write,
    .host_read, .direct_register_select, .host_rdata, .access_port_free_flag,
    .port_ctrl_a, .soft_reset_pulse);
`default_nettype wire

// ---- dv/ira_host.sv ----
// host model driving the port bus of both ports
`timescale 1ns/100ps
`default_nettype none
module ira_host (
    input wire logic clock,
    output logic [1:0] host_write,
    output logic [1:0] host_read,
    output logic [1:0][3:0] direct_register_select,
    output logic [1:0][31:0] host_wdata,
    input wire logic [1:0][31:0] host_rdata,
    input wire logic [1:0] access_port_free_flag
);
    // ********
    // bus cycles
    // ********
    int timeouts = 0;
    initial begin
        host_write = 2'b00;
        host_read = 2'b00;
        direct_register_select = '0;
        host_wdata = '0;
    end
    // no command word here, extension writes always allowed
    task automatic wr(input int p, input logic [3:0] s, input logic [31:0] d);
        @(posedge clock);
        #1;
        host_write[p] = 1'b1;
        direct_register_select[p] = s;
        host_wdata[p] = d;
        @(posedge clock);
        #1;
        host_write[p] = 1'b0;
        host_wdata[p] = ~d;
    endtask
    task automatic rd(input int p, input logic [3:0] s, output logic [31:0] q);
        @(posedge clock);
        #1;
        host_read[p] = 1'b1;
        direct_register_select[p] = s;
        @(posedge clock);
        #1;
        host_read[p] = 1'b0;
        q = host_rdata[p];
    endtask
    task automatic wait_free(input int p);
        int n = 0;
        while (access_port_free_flag[p] !== 1'b1 && n < 64) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 64) timeouts++;
    endtask
    task automatic acc(input int p, input logic r, input logic [3:0] t,
        input logic [2:0] i, input logic [7:0] d, output logic [7:0] q);
        logic [31:0] w;
        wait_free(p);
        wr(p, 4'hf, {r, t, i, d, 16'h0000});
        wait_free(p);
        rd(p, 4'hf, w);
        q = w[23:16];
    endtask
endmodule
`default_nettype wire
